// *** src/clock_divider_pkg.sv ***
// Purpose: Shared constants and carrier types for the system clock divider
// Assumes: One 50 MHz core clock; derived clocks are expressed as enable pulses
// Notes: Recovery delay is long; the top module exposes it as a parameter
package clock_divider_pkg;

  localparam int unsigned CORE_CLK_HZ = 50_000_000;
  // Power-on delay, typical figure in microseconds (5 to 6 ms band, lower edge)
  localparam int unsigned POR_DELAY_US = 5_000;
  localparam int unsigned POR_DELAY_CYCLES = (POR_DELAY_US * (CORE_CLK_HZ / 1_000_000));

  // Stop-recovery control field positions
  localparam int unsigned PRESCALE_BIT = 0;
  localparam int unsigned RECOVERY_DELAY_BIT = 5;
  localparam logic [7:0] STOP_RECOVERY_RESET = 8'h20;

  // Option byte 1 field position for the divide-by-1/2 choice
  localparam int unsigned DIV2_OPTION_BIT = 2;

  localparam int unsigned PRESCALE_RATIO = 16;

  typedef enum logic [1:0] {
    RUN_ST = 2'b00,
    HALT_ST = 2'b01,
    STOP_ST = 2'b11,
    WAKE_ST = 2'b10
  } power_state_t;

  typedef struct packed {
    logic system_tick;
    logic halt_interrupt_tick;
    logic oscillator_enable;
    logic cpu_running;
  } clock_out_t;

endpackage

// *** src/system_clock_divider.sv ***
// Purpose: Derive system and halt interrupt clock enables from the oscillator input
// Assumes: oscillator_input is asynchronous to CORE_CLK and much slower than it
// Notes: Derived clocks are one-cycle enables, so no gated clock leaves this block
//
// What this block does
// - CPU and peripherals run on derived system clock
// - Interrupt logic keeps running in halt
// - Option bit selects divide by one or two
// - Control bit 0 adds divide-by-16 stage
// - Reset and stop recovery clear prescaler enable
// - Control bit 5 selects stop wake delay
// - Without delay, execution resumes at once
// - Recovery delay equals power-on delay, 5-6 ms
// - Halt stops CPU clock, oscillator keeps running
// - Stop halts clocks and oscillator until wake
module system_clock_divider #(
  parameter int unsigned RECOVERY_CYCLES = clock_divider_pkg::POR_DELAY_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic OSCILLATOR_INPUT,
  input wire logic [7:0] OPTION_BYTE1,
  input wire logic [7:0] CONTROL_WDATA,
  input wire logic CONTROL_WRITE,
  input wire logic HALT_REQ,
  input wire logic STOP_REQ,
  input wire logic INTERRUPT_WAKE,
  input wire logic STOP_RECOVERY_EVENT,
  output logic [7:0] STOP_RECOVERY_CONTROL,
  output logic OSCILLATOR_OUTPUT,
  output clock_divider_pkg::clock_out_t CLOCKS,
  output logic [1:0] POWER_STATE
);
  import clock_divider_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // A zero delay would underflow the down-counter load to all ones
  if (RECOVERY_CYCLES < 1) begin : g_bad_recovery
    $error("RECOVERY_CYCLES must be at least one");
  end

  // The prescaler counter is four bits wide and wraps on its own
  if (PRESCALE_RATIO != 16) begin : g_bad_ratio
    $error("PRESCALE_RATIO must be sixteen");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser and rising-edge detect

  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;
  power_state_t state;

  // Two flops before anything reads the pin
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= OSCILLATOR_INPUT;
      osc_sync <= osc_meta;
    end
  end

  // Reset low matches the idle source, so no false edge follows reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_sync;
    end
  end

  // Edges are ignored while stopped: the oscillator is considered off
  assign osc_edge = osc_sync & ~osc_prev & (state != STOP_ST);

  ////////////////////////////////////////////////////////////////////////////
  // Divide-by-1/2 stage

  logic div2_phase;
  logic stage1_tick;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      div2_phase <= 1'b0;
    end else if (osc_edge) begin
      div2_phase <= ~div2_phase;
    end
  end

  // Option bit set passes every edge, clear takes every second edge
  assign stage1_tick = osc_edge & (OPTION_BYTE1[DIV2_OPTION_BIT] | div2_phase);

  ////////////////////////////////////////////////////////////////////////////
  // Stop-recovery control register and divide-by-16 prescaler

  logic prescale_active;
  logic [3:0] prescale_count;
  logic chain_tick;
  logic wake_event;

  assign wake_event = (state == STOP_ST) & STOP_RECOVERY_EVENT;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      STOP_RECOVERY_CONTROL <= STOP_RECOVERY_RESET;
    end else if (wake_event) begin
      STOP_RECOVERY_CONTROL[PRESCALE_BIT] <= 1'b0;
    end else if (CONTROL_WRITE) begin
      STOP_RECOVERY_CONTROL <= CONTROL_WDATA;
    end
  end

  // The requested enable is adopted on the next stage-one tick while the prescaler is off,
  // and only when it wraps while on, so a half-counted period never becomes a short derived clock
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prescale_active <= 1'b0;
      prescale_count <= 4'h0;
    end else if (wake_event) begin
      prescale_active <= 1'b0;
      prescale_count <= 4'h0;
    end else if (stage1_tick) begin
      prescale_count <= prescale_count + 4'h1;
      if (!prescale_active || prescale_count == 4'(PRESCALE_RATIO - 1)) begin
        prescale_active <= STOP_RECOVERY_CONTROL[PRESCALE_BIT];
        prescale_count <= 4'h0;
      end
    end
  end

  assign chain_tick = stage1_tick &
    (!prescale_active || prescale_count == 4'(PRESCALE_RATIO - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Power state: run, halt, stop and delayed wake

  logic [31:0] wake_count;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state <= RUN_ST;
    end else begin
      case (state)
        RUN_ST: begin
          if (STOP_REQ) begin
            state <= STOP_ST;
          end else if (HALT_REQ) begin
            state <= HALT_ST;
          end
        end
        HALT_ST: begin
          if (INTERRUPT_WAKE) begin
            state <= RUN_ST;
          end
        end
        STOP_ST: begin
          if (STOP_RECOVERY_EVENT) begin
            if (STOP_RECOVERY_CONTROL[RECOVERY_DELAY_BIT]) begin
              state <= WAKE_ST;
            end else begin
              state <= RUN_ST;
            end
          end
        end
        WAKE_ST: begin
          if (wake_count == 32'h0) begin
            state <= RUN_ST;
          end
        end
        default: begin
          state <= RUN_ST;
        end
      endcase
    end
  end

  // Counted on the core clock, as the power-on timer is; loaded with one
  // less than the delay because the exit cycle itself is part of it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wake_count <= 32'h0;
    end else if (wake_event && STOP_RECOVERY_CONTROL[RECOVERY_DELAY_BIT]) begin
      wake_count <= 32'(RECOVERY_CYCLES - 1);
    end else if (state == WAKE_ST && wake_count != 32'h0) begin
      wake_count <= wake_count - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      CLOCKS <= '0;
    end else begin
      CLOCKS.system_tick <= chain_tick & (state == RUN_ST);
      CLOCKS.halt_interrupt_tick <= chain_tick & (state == HALT_ST);
      CLOCKS.oscillator_enable <= (state != STOP_ST);
      CLOCKS.cpu_running <= (state == RUN_ST);
    end
  end

  // Feedback to the far side is silenced with the oscillator in stop
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      OSCILLATOR_OUTPUT <= 1'b0;
    end else begin
      OSCILLATOR_OUTPUT <= ~osc_sync & (state != STOP_ST);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      POWER_STATE <= 2'h0;
    end else begin
      POWER_STATE <= state;
    end
  end

endmodule

// *** verif/clk_div_sva.sv ***
// Purpose: Port checks for the clock divider
// Assumes: State and clock outputs lag a request by two cycles
// Notes: Bound from the foot of this file
module clk_div_sva #(
  parameter int unsigned RECOVERY_CYCLES = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] CONTROL_WDATA,
  input wire logic CONTROL_WRITE,
  input wire logic HALT_REQ,
  input wire logic STOP_REQ,
  input wire logic STOP_RECOVERY_EVENT,
  input wire logic [7:0] STOP_RECOVERY_CONTROL,
  input wire clock_divider_pkg::clock_out_t CLOCKS,
  input wire logic [1:0] POWER_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  import clock_divider_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic in_wake = POWER_STATE == WAKE_ST;
  wire logic stop_ev = POWER_STATE == STOP_ST && STOP_RECOVERY_EVENT;
  int unsigned wake_cnt;
  always_ff @(posedge CORE_CLK) begin
    wake_cnt <= (RST || !in_wake) ? 0 : wake_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  tick_pulse_a: assert property (CLOCKS.system_tick |=> !CLOCKS.system_tick)
    else $error("system tick too wide");
  tick_gate_a: assert property (CLOCKS.system_tick |-> CLOCKS.cpu_running)
    else $error("system tick while cpu stopped");
  halt_tick_a: assert property (CLOCKS.halt_interrupt_tick |-> POWER_STATE == HALT_ST)
    else $error("halt tick outside halt");
  // A stop request one cycle earlier has already moved the state out of run
  halt_entry_a: assert property (POWER_STATE == RUN_ST && HALT_REQ && !STOP_REQ
    && !$past(STOP_REQ) |-> ##2 POWER_STATE == HALT_ST && !CLOCKS.cpu_running)
    else $error("halt entry");
  stop_quiet_a: assert property ((POWER_STATE == STOP_ST)[*2] |->
    !CLOCKS.oscillator_enable && !CLOCKS.system_tick && !CLOCKS.halt_interrupt_tick)
    else $error("clock in stop");
  wake_clear_a: assert property (stop_ev |=> !STOP_RECOVERY_CONTROL[0])
    else $error("prescaler kept on wake");
  ctl_write_a: assert property (CONTROL_WRITE && !STOP_RECOVERY_EVENT |=>
    STOP_RECOVERY_CONTROL[5] == $past(CONTROL_WDATA[5])
    && STOP_RECOVERY_CONTROL[0] == $past(CONTROL_WDATA[0])) else $error("write lost");
  fast_wake_a: assert property (stop_ev && !STOP_RECOVERY_CONTROL[5]
    |-> ##2 POWER_STATE == RUN_ST && CLOCKS.cpu_running) else $error("wake delayed");
  wake_len_a: assert property (POWER_STATE == RUN_ST && $past(in_wake)
    |-> wake_cnt == RECOVERY_CYCLES) else $error("wake delay length");
  wake_cap_a: assert property (in_wake |-> wake_cnt < RECOVERY_CYCLES)
    else $error("wake delay overrun");
  cover property (POWER_STATE == HALT_ST && CLOCKS.halt_interrupt_tick);
  cover property (POWER_STATE == RUN_ST && $past(in_wake));
  cover property (CLOCKS.system_tick && STOP_RECOVERY_CONTROL[0]);
endmodule
bind system_clock_divider clk_div_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) i_sva (.CORE_CLK,
  .RST, .CONTROL_WDATA, .CONTROL_WRITE, .HALT_REQ, .STOP_REQ, .STOP_RECOVERY_EVENT,
  .STOP_RECOVERY_CONTROL, .CLOCKS, .POWER_STATE);

// *** verif/osc_source.sv ***
// Purpose: External clock source on the oscillator input
// Assumes: Half period far above two core cycles
// Notes: Stands still at 0 while the device stops its oscillator
module osc_source #(parameter int HALF = 100) (
  input wire logic en,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc = 1'b0;
  always begin
    #HALF;
    osc = (en === 1'b1) ? ~osc : 1'b0;
  end
endmodule

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the clock divider
// Assumes: 5 MHz source, so one source period is ten core cycles
// Notes: Recovery delay shortened to 8 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_divider_pkg::*;
  localparam int WAKE_CYCLES = 8;
  logic clk = 0, rst = 1, osc, cw = 0, hr = 0, sr = 0, iw = 0, ev = 0, oo;
  logic [7:0] opt = 8'h04, wd = 8'h00, ctl;
  logic [1:0] ps;
  clock_out_t ck;
  int num_errors = 0, n_tests = 0, cyc = 0, s, h;
  always #10 clk = ~clk;
  osc_source i_osc (.en(ck.oscillator_enable), .osc(osc));
  system_clock_divider #(.RECOVERY_CYCLES(WAKE_CYCLES)) i_dut (.CORE_CLK(clk), .RST(rst),
    .OSCILLATOR_INPUT(osc), .OPTION_BYTE1(opt), .CONTROL_WDATA(wd), .CONTROL_WRITE(cw),
    .HALT_REQ(hr), .STOP_REQ(sr), .INTERRUPT_WAKE(iw), .STOP_RECOVERY_EVENT(ev),
    .STOP_RECOVERY_CONTROL(ctl), .OSCILLATOR_OUTPUT(oo), .CLOCKS(ck), .POWER_STATE(ps));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t count %0d", $time, got);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic count(input int n);
    s = 0;
    h = 0;
    repeat (n) begin
      @(negedge clk);
      s += int'(ck.system_tick === 1'b1);
      h += int'(ck.halt_interrupt_tick === 1'b1);
    end
  endtask
  task automatic pulse(ref logic x);
    @(negedge clk);
    x = 1;
    @(negedge clk);
    x = 0;
  endtask
  task automatic test_div;
    count(400);
    chk(s, 39, 41);
    opt = 8'h00;
    count(400);
    chk(s, 19, 21);
    $display("test_div done");
  endtask
  task automatic test_pre;
    opt = 8'h04;
    wd = 8'h21;
    pulse(cw);
    chk8(ctl, 8'h21);
    count(100);
    count(640);
    chk(s, 3, 5);
    pulse(hr);
    count(20);
    count(640);
    chk(s, 0, 0);
    chk(h, 3, 5);
    pulse(iw);
    count(20);
    $display("test_pre done");
  endtask
  task automatic test_stop(input logic d);
    int n;
    wd = {2'b00, d, 5'h01};
    pulse(cw);
    pulse(sr);
    repeat (3) @(negedge clk);
    chk8({6'h00, ps}, {6'h00, STOP_ST});
    chk8({7'h00, ck.oscillator_enable}, 8'h00);
    chk8({7'h00, oo}, 8'h00);
    pulse(ev);
    // One edge after the event the state shows, so every wake cycle is counted
    @(negedge clk);
    chk8(ctl, {2'b00, d, 5'h00});
    chk8({6'h00, ps}, {6'h00, d ? WAKE_ST : RUN_ST});
    n = 0;
    while (ps === WAKE_ST && n < 50) begin
      n++;
      @(negedge clk);
    end
    chk(n, d ? WAKE_CYCLES : 0, d ? WAKE_CYCLES : 0);
    $display("test_stop done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    chk8(ctl, STOP_RECOVERY_RESET);
    test_div;
    test_pre;
    test_stop(1'b1);
    test_stop(1'b0);
    summarize;
  end
endmodule
